// *** design/lctg_pkg.sv ***
// Constants, types and field layout of the limiter, clip and thermal gain register slice
// Notes on behaviour
// (RULE1) Right threshold code in bits 7:3, reset 0xA, 16 V down to 2 V.
// (RULE2) Right slope in bits 1:0, reset 1, ratios 1:1 to 4:1.
// (RULE3) Right threshold register reads 0x51 after reset; bit 2 reads zero.
// (RULE4) Right battery knee point is a full 8-bit read/write value, reset 0x22.
// (RULE5) Left clip code N limits output to (N+1)/256, reset 0xFF.
// (RULE6) Right clip uses the same coding and resets to full scale.
// (RULE7) Right thermal gain cut in bits 5:4: 0, 1.5, 3, 5.625 dB.
// (RULE8) Left thermal gain cut in bits 1:0, same steps, default none.
// (RULE9) Thermal gain register resets 0x00; bits 7:6 and 3:2 read zero.
// (RULE10) Fault recovery register at 0x17 reads 0x30 after reset.
// (RULE11) With channel join set, right limiter follows the left limiter settings.
// (RULE12) With tracking on, threshold drops below knee point following the slope.
// (RULE13) Thermal gain cut ends when warning clears, reapplied at next warning.
package lctg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] LCTG_OFS_RTHR   = 8'h12;
  localparam logic [7:0] LCTG_OFS_RKNEE  = 8'h13;
  localparam logic [7:0] LCTG_OFS_LCLIP  = 8'h14;
  localparam logic [7:0] LCTG_OFS_RCLIP  = 8'h15;
  localparam logic [7:0] LCTG_OFS_TGAIN  = 8'h16;
  localparam logic [7:0] LCTG_OFS_FREC   = 8'h17;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] LCTG_RST_RTHR   = 8'h51;
  localparam logic [7:0] LCTG_RST_RKNEE  = 8'h22;
  localparam logic [7:0] LCTG_RST_CLIP   = 8'hff;
  localparam logic [7:0] LCTG_RST_TGAIN  = 8'h00;
  localparam logic [7:0] LCTG_RST_FREC   = 8'h30;
  localparam logic [7:0] LCTG_MSK_RTHR   = 8'hfb;
  localparam logic [7:0] LCTG_MSK_FULL   = 8'hff;
  localparam logic [7:0] LCTG_MSK_TGAIN  = 8'h33;
  localparam logic [7:0] LCTG_MSK_FREC   = 8'h30;
  localparam logic [7:0] LCTG_RD_ZERO    = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LCTG_THR_LSB    = 3;
  localparam int LCTG_THR_MSB    = 7;
  localparam int LCTG_SLOPE_LSB  = 0;
  localparam int LCTG_SLOPE_MSB  = 1;
  localparam int LCTG_TGR_LSB    = 4;
  localparam int LCTG_TGR_MSB    = 5;
  localparam int LCTG_TGL_LSB    = 0;
  localparam int LCTG_TGL_MSB    = 1;
  localparam int LCTG_MRCV_BIT   = 7;

  // ****************************************
  // Threshold decode, units of 0.25 V
  // ****************************************
  localparam logic [4:0] LCTG_THR_KNEE1  = 5'h0d;
  localparam logic [4:0] LCTG_THR_KNEE2  = 5'h13;
  localparam logic [6:0] LCTG_THR_TOP    = 7'h40;
  localparam logic [6:0] LCTG_THR_AT_K1  = 7'h26;
  localparam logic [6:0] LCTG_THR_AT_K2  = 7'h20;

  // ****************************************
  // Thermal gain cut, units of 0.125 dB
  // ****************************************
  localparam logic [5:0] LCTG_CUT_0      = 6'h00;
  localparam logic [5:0] LCTG_CUT_1      = 6'h0c;
  localparam logic [5:0] LCTG_CUT_2      = 6'h18;
  localparam logic [5:0] LCTG_CUT_3      = 6'h2d;

  // Limiter settings of one channel
  typedef struct packed {
    logic [4:0] thr_code;
    logic [1:0] slope;
    logic [7:0] knee;
    logic       track_en;
  } lctg_lim_s;

  // Protection outputs of one channel
  typedef struct packed {
    logic [8:0] clip_level;
    logic [5:0] gain_cut;
  } lctg_prot_s;

  typedef enum logic [1:0] {
    LCTG_TW_IDLE = 2'b01,
    LCTG_TW_CUT  = 2'b10
  } lctg_tw_e;

endpackage : lctg_pkg

// *** design/lctg_reg8.sv ***
// One 8-bit configuration register with writable mask and reset value
`timescale 1ns/1ps
module lctg_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);
  logic [7:0] val_r;
  logic [7:0] val_nxt;

  // Unwritable bits keep their reset value
  always_comb begin
    val_nxt = val_r;
    if (wr_en) begin
      val_nxt = (wdata & WR_MASK) | (RST_VAL & ~WR_MASK);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      val_r <= RST_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign q = val_r;
endmodule : lctg_reg8

// *** design/lctg_thr_track.sv ***
// Limiter threshold decode and battery tracking for one channel
`timescale 1ns/1ps
module lctg_thr_track (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire lctg_pkg::lctg_lim_s lim,
  input  wire logic [7:0]          vbat,
  output logic      [6:0]          thr_q
);
  import lctg_pkg::*;

  logic [6:0]  base;
  logic [9:0]  drop;
  logic [8:0]  deficit;
  logic [6:0]  thr_r;
  logic [6:0]  thr_nxt;

  // (RULE1) Piecewise decode
  always_comb begin
    if (lim.thr_code <= LCTG_THR_KNEE1) begin
      base = LCTG_THR_TOP - {1'b0, lim.thr_code, 1'b0};
    end else if (lim.thr_code <= LCTG_THR_KNEE2) begin
      base = LCTG_THR_AT_K1 - {2'b00, lim.thr_code - LCTG_THR_KNEE1};
    end else begin
      base = LCTG_THR_AT_K2 - {1'b0, lim.thr_code - LCTG_THR_KNEE2, 1'b0};
    end
  end

  // (RULE12) Ramp down below knee point
  always_comb begin
    deficit = {1'b0, lim.knee} - {1'b0, vbat};
    drop    = {2'b00, deficit[7:0]} * {7'h00, {1'b0, lim.slope} + 3'h1};
    thr_nxt = base;
    if (lim.track_en && (vbat < lim.knee)) begin
      thr_nxt = (drop >= {3'b000, base}) ? 7'h00 : 7'(({3'b000, base} - drop));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thr_r <= LCTG_THR_TOP;
    end else begin
      thr_r <= thr_nxt;
    end
  end

  assign thr_q = thr_r;
endmodule : lctg_thr_track

// *** design/lctg_regs.sv ***
// Limiter, clip level and thermal gain register slice of the output protection path
`timescale 1ns/1ps
module lctg_regs (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_hit,
  input  wire lctg_pkg::lctg_lim_s  left_lim,
  input  wire logic                 limiter_channel_join,
  input  wire logic                 right_track_en,
  input  wire logic [7:0]           vbat,
  input  wire logic                 thermal_warning,
  output logic      [6:0]           right_limit_q,
  output logic                      right_knee_below,
  output lctg_pkg::lctg_prot_s      left_prot,
  output lctg_pkg::lctg_prot_s      right_prot,
  output logic      [1:0]           max_recovery,
  output logic                      manual_recover
);
  import lctg_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  logic       wr_rthr;
  logic       wr_rknee;
  logic       wr_lclip;
  logic       wr_rclip;
  logic       wr_tgain;
  logic       wr_frec;
  logic       addr_ok;

  always_comb begin
    wr_rthr  = reg_wr && (reg_addr == LCTG_OFS_RTHR);
    wr_rknee = reg_wr && (reg_addr == LCTG_OFS_RKNEE);
    wr_lclip = reg_wr && (reg_addr == LCTG_OFS_LCLIP);
    wr_rclip = reg_wr && (reg_addr == LCTG_OFS_RCLIP);
    wr_tgain = reg_wr && (reg_addr == LCTG_OFS_TGAIN);
    wr_frec  = reg_wr && (reg_addr == LCTG_OFS_FREC);
    addr_ok  = (reg_addr >= LCTG_OFS_RTHR) && (reg_addr <= LCTG_OFS_FREC);
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] rthr_q;
  logic [7:0] rknee_q;
  logic [7:0] lclip_q;
  logic [7:0] rclip_q;
  logic [7:0] tgain_q;
  logic [7:0] frec_q;

  // (RULE1) Threshold and slope storage
  lctg_reg8 #(
    .RST_VAL (LCTG_RST_RTHR),
    .WR_MASK (LCTG_MSK_RTHR)
  ) u_rthr (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_rthr),
    .wdata (reg_wdata),
    .q     (rthr_q)
  );

  // (RULE4) Knee point storage
  lctg_reg8 #(
    .RST_VAL (LCTG_RST_RKNEE),
    .WR_MASK (LCTG_MSK_FULL)
  ) u_rknee (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_rknee),
    .wdata (reg_wdata),
    .q     (rknee_q)
  );

  // (RULE5) Left clip storage
  lctg_reg8 #(
    .RST_VAL (LCTG_RST_CLIP),
    .WR_MASK (LCTG_MSK_FULL)
  ) u_lclip (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_lclip),
    .wdata (reg_wdata),
    .q     (lclip_q)
  );

  // (RULE6) Right clip storage
  lctg_reg8 #(
    .RST_VAL (LCTG_RST_CLIP),
    .WR_MASK (LCTG_MSK_FULL)
  ) u_rclip (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_rclip),
    .wdata (reg_wdata),
    .q     (rclip_q)
  );

  // (RULE9) Reserved bits masked
  lctg_reg8 #(
    .RST_VAL (LCTG_RST_TGAIN),
    .WR_MASK (LCTG_MSK_TGAIN)
  ) u_tgain (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_tgain),
    .wdata (reg_wdata),
    .q     (tgain_q)
  );

  // (RULE10) Recovery count storage
  lctg_reg8 #(
    .RST_VAL (LCTG_RST_FREC),
    .WR_MASK (LCTG_MSK_FREC)
  ) u_frec (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_frec),
    .wdata (reg_wdata),
    .q     (frec_q)
  );

  // ****************************************
  // Register readback
  // ****************************************
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       mrcv_r;
  logic       mrcv_nxt;

  // (RULE3) Reserved bit reads zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        LCTG_OFS_RTHR:  rdata_nxt = rthr_q & LCTG_MSK_RTHR;
        LCTG_OFS_RKNEE: rdata_nxt = rknee_q;
        LCTG_OFS_LCLIP: rdata_nxt = lclip_q;
        LCTG_OFS_RCLIP: rdata_nxt = rclip_q;
        LCTG_OFS_TGAIN: rdata_nxt = tgain_q & LCTG_MSK_TGAIN;
        LCTG_OFS_FREC:  rdata_nxt = frec_q & LCTG_MSK_FREC;
        default:        rdata_nxt = LCTG_RD_ZERO;
      endcase
    end
    // Manual recovery is write-one, one pulse, never stored
    mrcv_nxt = wr_frec && reg_wdata[LCTG_MRCV_BIT];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= LCTG_RD_ZERO;
      mrcv_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      mrcv_r  <= mrcv_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign reg_hit        = addr_ok;
  assign manual_recover = mrcv_r;
  assign max_recovery   = frec_q[5:4];

  // ****************************************
  // Right limiter settings
  // ****************************************
  lctg_lim_s right_own;
  lctg_lim_s right_eff;

  always_comb begin
    right_own.thr_code = rthr_q[LCTG_THR_MSB:LCTG_THR_LSB];
    // (RULE2) Slope field
    right_own.slope    = rthr_q[LCTG_SLOPE_MSB:LCTG_SLOPE_LSB];
    right_own.knee     = rknee_q;
    right_own.track_en = right_track_en;
    // (RULE11) Joined channels use left settings
    right_eff = limiter_channel_join ? left_lim : right_own;
  end

  // (RULE12) Threshold tracking
  lctg_thr_track u_rtrack (
    .mclk  (mclk),
    .rst_n (rst_n),
    .lim   (right_eff),
    .vbat  (vbat),
    .thr_q (right_limit_q)
  );

  logic below_r;
  logic below_nxt;

  always_comb begin
    below_nxt = vbat < right_eff.knee;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      below_r <= 1'b0;
    end else begin
      below_r <= below_nxt;
    end
  end

  assign right_knee_below = below_r;

  // ****************************************
  // Thermal warning synchroniser
  // ****************************************
  logic tw_s1_r;
  logic tw_s2_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tw_s1_r <= 1'b0;
      tw_s2_r <= 1'b0;
    end else begin
      tw_s1_r <= thermal_warning;
      tw_s2_r <= tw_s1_r;
    end
  end

  // ****************************************
  // Thermal gain cut sequencing
  // ****************************************
  lctg_tw_e   tw_r;
  lctg_tw_e   tw_nxt;
  lctg_prot_s lprot_r;
  lctg_prot_s lprot_nxt;
  lctg_prot_s rprot_r;
  lctg_prot_s rprot_nxt;

  function automatic logic [5:0] lctg_cut(input logic [1:0] code);
    logic [5:0] cut;
    unique case (code)
      2'h0: cut = LCTG_CUT_0;
      2'h1: cut = LCTG_CUT_1;
      2'h2: cut = LCTG_CUT_2;
      2'h3: cut = LCTG_CUT_3;
    endcase
    return cut;
  endfunction : lctg_cut

  // (RULE13) Cut only while warning holds
  always_comb begin
    tw_nxt = tw_r;
    unique case (tw_r)
      LCTG_TW_IDLE: if (tw_s2_r) begin
        tw_nxt = LCTG_TW_CUT;
      end
      LCTG_TW_CUT: if (!tw_s2_r) begin
        tw_nxt = LCTG_TW_IDLE;
      end
      default: tw_nxt = LCTG_TW_IDLE;
    endcase
  end

  always_comb begin
    // (RULE5) Left clip fraction N+1
    lprot_nxt.clip_level = {1'b0, lclip_q} + 9'h001;
    // (RULE6) Right clip fraction N+1
    rprot_nxt.clip_level = {1'b0, rclip_q} + 9'h001;
    // (RULE8) Left cut steps
    lprot_nxt.gain_cut   = (tw_nxt == LCTG_TW_CUT) ?
                           lctg_cut(tgain_q[LCTG_TGL_MSB:LCTG_TGL_LSB]) : LCTG_CUT_0;
    // (RULE7) Right cut steps
    rprot_nxt.gain_cut   = (tw_nxt == LCTG_TW_CUT) ?
                           lctg_cut(tgain_q[LCTG_TGR_MSB:LCTG_TGR_LSB]) : LCTG_CUT_0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tw_r    <= LCTG_TW_IDLE;
      lprot_r <= '{clip_level: 9'h100, gain_cut: LCTG_CUT_0};
      rprot_r <= '{clip_level: 9'h100, gain_cut: LCTG_CUT_0};
    end else begin
      tw_r    <= tw_nxt;
      lprot_r <= lprot_nxt;
      rprot_r <= rprot_nxt;
    end
  end

  assign left_prot  = lprot_r;
  assign right_prot = rprot_r;
endmodule : lctg_regs

// *** tb/lctg_regs_checker.sv ***
// Port assertions for the limiter, clip and thermal gain register slice
`timescale 1ns/1ps
module lctg_regs_checker (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 thermal_warning,
  input wire logic [6:0]           right_limit_q,
  input wire lctg_pkg::lctg_prot_s left_prot,
  input wire lctg_pkg::lctg_prot_s right_prot
);
  import lctg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Assertions
  // ****************************************
  property p_thr_rsvd;
    reg_rd && reg_addr == 8'h12 |=> !reg_rdata[2];
  endproperty
  a_thr_rsvd: assert property (p_thr_rsvd) else $error("threshold spare bit set");
  property p_tg_rsvd;
    reg_rd && reg_addr == 8'h16 |=> (reg_rdata & 8'hcc) == 8'h00;
  endproperty
  a_tg_rsvd: assert property (p_tg_rsvd) else $error("gain spare bits set");
  property p_frec;
    reg_rd && reg_addr == 8'h17 |=> (reg_rdata & 8'hcf) == 8'h00;
  endproperty
  a_frec: assert property (p_frec) else $error("recovery spare bits set");
  property p_lclip;
    reg_wr && reg_addr == 8'h14 ##1 !(reg_wr && reg_addr == 8'h14)
      |=> left_prot.clip_level == {1'b0, $past(reg_wdata, 2)} + 9'd1;
  endproperty
  a_lclip: assert property (p_lclip) else $error("left clip level wrong");
  property p_rclip;
    reg_wr && reg_addr == 8'h15 ##1 !(reg_wr && reg_addr == 8'h15)
      |=> right_prot.clip_level == {1'b0, $past(reg_wdata, 2)} + 9'd1;
  endproperty
  a_rclip: assert property (p_rclip) else $error("right clip level wrong");
  property p_cut_off;
    !thermal_warning [*3] |=> left_prot.gain_cut == 6'h00 && right_prot.gain_cut == 6'h00;
  endproperty
  a_cut_off: assert property (p_cut_off) else $error("gain cut without warning");
  property p_cut_set;
    right_prot.gain_cut inside {6'h00, 6'h0c, 6'h18, 6'h2d} &&
      left_prot.gain_cut inside {6'h00, 6'h0c, 6'h18, 6'h2d};
  endproperty
  a_cut_set: assert property (p_cut_set) else $error("gain cut off table");
  property p_thr_max;
    right_limit_q <= 7'd64;
  endproperty
  a_thr_max: assert property (p_thr_max) else $error("threshold above top");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : lctg_regs_checker

bind lctg_regs lctg_regs_checker lctg_regs_checker_i (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .thermal_warning(thermal_warning),
  .right_limit_q(right_limit_q), .left_prot(left_prot), .right_prot(right_prot));

// *** tb/lctg_regs_bench.sv ***
// Self-checking bench for the register slice
`timescale 1ns/1ps
module lctg_regs_bench;
  import lctg_pkg::*;
  logic       mclk, rst_n, reg_wr, reg_rd, join_en, track_en, warn;
  logic       reg_hit, knee_below, manual_recover, rd_pend;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vbat;
  logic [6:0] right_limit_q;
  logic [1:0] max_recovery;
  lctg_lim_s  left_lim;
  lctg_prot_s left_prot, right_prot;
  logic [7:0] exp_q[$];
  int         fails, n_checks;
  logic [31:0] rv;
  localparam logic [7:0] RST [6] = '{8'h51, 8'h22, 8'hff, 8'hff, 8'h00, 8'h30};
  localparam logic [7:0] MSK [6] = '{8'hfb, 8'hff, 8'hff, 8'hff, 8'h33, 8'h30};
  localparam logic [5:0] CUT [4] = '{6'h00, 6'h0c, 6'h18, 6'h2d};

  lctg_regs lctg_regs_i (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .left_lim(left_lim),
    .limiter_channel_join(join_en), .right_track_en(track_en), .vbat(vbat),
    .thermal_warning(warn), .right_limit_q(right_limit_q), .right_knee_below(knee_below),
    .left_prot(left_prot), .right_prot(right_prot), .max_recovery(max_recovery),
    .manual_recover(manual_recover));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic settle(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Read data answers the read taken one edge earlier
  always @(posedge mclk) begin
    if (rd_pend) begin
      chk("reg_rdata", {1'b0, exp_q.pop_front()}, {1'b0, reg_rdata});
    end
    rd_pend <= reg_rd;
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #100us;
    fails++;
    close_out();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {rst_n, reg_wr, reg_rd, join_en, track_en, warn, rd_pend} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    vbat = 8'h30;
    left_lim = '{thr_code: 5'd31, slope: 2'd0, knee: 8'h22, track_en: 1'b0};
    void'($urandom(32'h177e));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    settle(2);
    chk("right_limit_q", 9'd44, 9'(right_limit_q));
    chk("max_recovery", 9'd3, 9'(max_recovery));
    for (int i = 0; i < 6; i++) rd(8'h12 + 8'(i), RST[i]);
    settle(0);
    chk("reg_hit", 9'd1, 9'(reg_hit));
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h00);
    settle(0);
    chk("reg_hit", 9'd0, 9'(reg_hit));
    rd(8'h12, 8'h51);
    for (int i = 0; i < 6; i++) begin
      rv = $urandom;
      wr(8'h12 + 8'(i), rv[7:0]);
      rd(8'h12 + 8'(i), rv[7:0] & MSK[i]);
      wr(8'h12 + 8'(i), 8'hff);
      rd(8'h12 + 8'(i), MSK[i]);
    end
    // Recovery pulse stands one cycle, count field keeps bits 5:4
    wr(8'h17, 8'h90);
    settle(0);
    chk("manual_recover", 9'd1, 9'(manual_recover));
    chk("max_recovery", 9'd1, 9'(max_recovery));
    settle(1);
    chk("manual_recover", 9'd0, 9'(manual_recover));
    rd(8'h17, 8'h10);
    // Clip codes, both ends of the range first
    for (int i = 0; i < 4; i++) begin
      rv = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff : $urandom;
      wr(8'h14, rv[7:0]);
      wr(8'h15, rv[15:8]);
      settle(2);
      chk("left_clip", {1'b0, rv[7:0]} + 9'd1, left_prot.clip_level);
      chk("right_clip", {1'b0, rv[15:8]} + 9'd1, right_prot.clip_level);
    end
    for (int k = 0; k < 32; k++) begin
      wr(8'h12, {k[4:0], 3'b001});
      settle(2);
      chk("right_limit_q", 9'(k <= 13 ? 64 - 2 * k : k <= 19 ? 51 - k : 70 - 2 * k),
          9'(right_limit_q));
    end
    wr(8'h13, 8'h22);
    track_en <= 1'b1;
    vbat <= 8'h20;
    for (int s = 0; s < 4; s++) begin
      wr(8'h12, {6'd0, s[1:0]});
      settle(2);
      chk("right_limit_q", 9'(62 - 2 * s), 9'(right_limit_q));
      chk("knee_below", 9'd1, 9'(knee_below));
    end
    @(posedge mclk);
    vbat <= 8'h30;
    settle(2);
    chk("right_limit_q", 9'd64, 9'(right_limit_q));
    chk("knee_below", 9'd0, 9'(knee_below));
    @(posedge mclk);
    join_en <= 1'b1;
    settle(2);
    chk("right_limit_q", 9'd8, 9'(right_limit_q));
    @(posedge mclk);
    join_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h16, {2'b00, 2'(3 - i), 2'b00, 2'(i)});
      warn <= 1'b1;
      settle(4);
      chk("left_cut", 9'(CUT[i]), 9'(left_prot.gain_cut));
      chk("right_cut", 9'(CUT[3 - i]), 9'(right_prot.gain_cut));
      @(posedge mclk);
      warn <= 1'b0;
      settle(4);
      chk("left_cut", 9'd0, 9'(left_prot.gain_cut));
      chk("right_cut", 9'd0, 9'(right_prot.gain_cut));
    end
    settle(3);
    close_out();
  end
endmodule : lctg_regs_bench
